/* File: verilog/eeprom_consts.svh */
// Timing counts, sizes and codes shared by both ends of the EEPROM link.
// Assumes a 100 MHz system clock at each end.
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define SYS_CLK_MHZ 100
`define WRITE_CYCLE_NS 20000
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS * `SYS_CLK_MHZ) / 1000)
`define TOC_HALF_NS 5000
`define TOC_HALF_CYC ((`TOC_HALF_NS * `SYS_CLK_MHZ) / 1000)
`define ARRAY_DEPTH 128
// Arbitrary address value
`define DEFAULT_DEV_ADDR 7'h3a
`define BYTE_BITS 4'h8
`endif

/* File: verilog/eeprom_pkg.sv */
// Types shared by the EEPROM device and its bus master.
// Assumes nothing of its surroundings.
package eeprom_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_CTRL = 7'h02, ST_WORD = 7'h04, ST_DATA = 7'h08,
    ST_ACK  = 7'h10, ST_TX   = 7'h20, ST_MACK = 7'h40
  } dev_state_t;
  typedef enum logic [3:0] {
    OP_IDLE = 4'h1, OP_START = 4'h2, OP_BIT = 4'h4, OP_STOP = 4'h8
  } bus_op_t;
  typedef enum logic [3:0] {
    K_WRITE = 4'h1, K_POLL = 4'h2, K_CUR_READ = 4'h4, K_RAND_READ = 4'h8
  } cmd_kind_t;
  typedef enum logic [6:0] {
    SP_START = 7'h01, SP_CTRL_W = 7'h02, SP_CTRL_R = 7'h04, SP_WORD = 7'h08,
    SP_DATA  = 7'h10, SP_READ   = 7'h20, SP_STOP   = 7'h40
  } step_t;
endpackage : eeprom_pkg

/* File: verilog/eeprom_if.sv */
// Two-wire link plus transmit-only clock between master and device.
// Assumes the pull-up on the data line; the line resolves here.
`timescale 1ns/1ps
`default_nettype none
interface eeprom_if;
  logic scl;
  logic transmit_only_clock;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic sda;
  // Open drain: any enabled low driver pulls the line down
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
  modport device (input scl, transmit_only_clock, sda,
                  output dev_sda_o, dev_sda_oe);
  modport host (output scl, transmit_only_clock, host_sda_o, host_sda_oe,
                input sda);
endinterface : eeprom_if
`default_nettype wire

/* File: verilog/eeprom_device.sv */
// EEPROM slave: transmit-only stream, two-wire read/write, timed write.
// Assumes link pins are asynchronous to sys_clk and far slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.svh"
module eeprom_device #(
  parameter int         DEPTH    = `ARRAY_DEPTH,
  parameter logic [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR, // Arbitrary value
  parameter int         WR_CYC   = `WRITE_CYCLE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  eeprom_if.device  bus,
  input  wire logic supply_ok,
  output logic      write_busy,
  output logic      bidir_mode
);
  import eeprom_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int WW = $clog2(WR_CYC + 1);

  // Wrapping pointer relies on a power-of-two depth
  if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two from 2 to 256");
  end
  if (WR_CYC < 1) begin : g_chk_wr
    $error("WR_CYC must be at least one");
  end

  logic [7:0]    mem [DEPTH];
  logic [3:0]    sy1;
  logic [3:0]    sy2;
  logic [3:0]    sy3;
  dev_state_t    st;
  dev_state_t    after;
  logic [3:0]    cnt;
  logic [7:0]    sh;
  logic [AW-1:0] ptr;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_buf;
  logic          wr_pend;
  logic          wp_ok;
  logic          more;
  logic          drive;
  logic          sda_o_q;
  logic [WW-1:0] wcnt;

  // Pin order in the synchroniser: supply, clock pin, data, scl
  wire scl_h     = sy2[0];
  wire sda_h     = sy2[1];
  wire toc_h     = sy2[2];
  wire sup_h     = sy2[3];
  wire scl_rise  = sy2[0] && !sy3[0];
  wire scl_fall  = !sy2[0] && sy3[0];
  wire sda_rise  = sy2[1] && !sy3[1];
  wire sda_fall  = !sy2[1] && sy3[1];
  wire toc_rise  = sy2[2] && !sy3[2];
  wire start_c   = scl_h && sy3[0] && sda_fall;
  wire stop_c    = scl_h && sy3[0] && sda_rise;
  wire byte_end  = scl_fall && cnt == `BYTE_BITS;
  wire [7:0] rd_byte = mem[ptr];
  wire addr_hit  = sh[7:1] == DEV_ADDR && !write_busy;
  wire [AW-1:0] ptr_inc = ptr + 1'b1;
  // The STOP's own clock rise counts one bit: a byte boundary reads cnt 1
  wire commit    = stop_c && wr_pend && wp_ok && sup_h && !write_busy
                   && st == ST_DATA && cnt == 4'h1;
  wire wr_done   = write_busy && wcnt == '0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sy1 <= 4'hf;
      sy2 <= 4'hf;
      sy3 <= 4'hf;
    end else begin
      sy1 <= {supply_ok, bus.transmit_only_clock, bus.sda, bus.scl};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // Device can only pull low; the pull-up makes the high
  always_ff @(posedge sys_clk) begin
    sda_o_q <= 1'b0;
  end
  assign bus.dev_sda_o  = sda_o_q;
  assign bus.dev_sda_oe = drive;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      write_busy <= 1'b0;
      wcnt       <= '0;
    end else if (commit) begin
      write_busy <= 1'b1;
      wcnt       <= WW'(WR_CYC - 1);
    end else if (write_busy) begin
      if (wcnt == '0) begin
        write_busy <= 1'b0;
      end else begin
        wcnt <= wcnt - 1'b1;
      end
    end
  end

  // Array is not reset; it models nonvolatile contents
  always_ff @(posedge sys_clk) begin
    if (wr_done && sup_h) begin
      mem[wr_addr] <= wr_buf;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st         <= ST_IDLE;
      after      <= ST_IDLE;
      bidir_mode <= 1'b0;
      drive      <= 1'b0;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      ptr        <= '0;
      wr_addr    <= '0;
      wr_buf     <= 8'h00;
      wr_pend    <= 1'b0;
      wp_ok      <= 1'b0;
      more       <= 1'b0;
    end else if (!bidir_mode) begin
      if (scl_fall) begin
        bidir_mode <= 1'b1;
        drive      <= 1'b0;
        cnt        <= 4'h0;
      end else if (toc_rise) begin
        // Byte boundary: fetch next byte and put out its top bit
        if (cnt == 4'h0) begin
          drive <= ~rd_byte[7];
          sh    <= {rd_byte[6:0], 1'b0};
          ptr   <= ptr_inc;
          cnt   <= 4'h7;
        end else begin
          drive <= ~sh[7];
          sh    <= {sh[6:0], 1'b0};
          cnt   <= cnt - 1'b1;
        end
      end
    end else if (start_c) begin
      st      <= ST_CTRL;
      cnt     <= 4'h0;
      drive   <= 1'b0;
      wr_pend <= 1'b0;
      wp_ok   <= toc_h;
    end else if (stop_c) begin
      st      <= ST_IDLE;
      drive   <= 1'b0;
      wr_pend <= 1'b0;
    end else begin
      if (!toc_h) begin
        wp_ok <= 1'b0;
      end
      unique case (st)
        ST_IDLE: begin
          drive <= 1'b0;
        end
        ST_CTRL, ST_WORD, ST_DATA: begin
          if (scl_rise && cnt != `BYTE_BITS) begin
            sh  <= {sh[6:0], sda_h};
            cnt <= cnt + 1'b1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            if (st == ST_CTRL) begin
              if (addr_hit) begin
                drive <= 1'b1;
                st    <= ST_ACK;
                after <= sh[0] ? ST_TX : ST_WORD;
              end else begin
                st <= ST_IDLE;
              end
            end else if (st == ST_WORD) begin
              ptr   <= sh[AW-1:0];
              drive <= 1'b1;
              st    <= ST_ACK;
              after <= ST_DATA;
            end else begin
              wr_buf  <= sh;
              wr_addr <= ptr;
              ptr     <= ptr_inc;
              wr_pend <= 1'b1;
              drive   <= 1'b1;
              st      <= ST_ACK;
              after   <= ST_DATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st <= after;
            if (after == ST_TX) begin
              drive <= ~rd_byte[7];
              sh    <= {rd_byte[6:0], 1'b0};
              ptr   <= ptr_inc;
              cnt   <= 4'h1;
            end else begin
              drive <= 1'b0;
              cnt   <= 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt == `BYTE_BITS) begin
              drive <= 1'b0;
              st    <= ST_MACK;
            end else begin
              drive <= ~sh[7];
              sh    <= {sh[6:0], 1'b0};
              cnt   <= cnt + 1'b1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            more <= !sda_h;
          end else if (scl_fall) begin
            if (more) begin
              drive <= ~rd_byte[7];
              sh    <= {rd_byte[6:0], 1'b0};
              ptr   <= ptr_inc;
              cnt   <= 4'h1;
              st    <= ST_TX;
            end else begin
              drive <= 1'b0;
              st    <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : eeprom_device
`default_nettype wire

/* File: verilog/eeprom_host.sv */
// Bus master for the EEPROM: makes SCL, START/STOP and the clock pin.
// Assumes one command at a time from a user on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.svh"
module eeprom_host #(
  parameter logic [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR, // Arbitrary value
  parameter int         QC       = `SCL_QUARTER_CYC,
  parameter int         TC       = `TOC_HALF_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  eeprom_if.host                     bus,
  input  wire logic                  cmd_valid,
  input  wire eeprom_pkg::cmd_kind_t cmd_kind,
  input  wire logic [7:0]            cmd_addr,
  input  wire logic [7:0]            cmd_wdata,
  input  wire logic [7:0]            cmd_len,
  input  wire logic                  toc_run,
  input  wire logic                  write_enable,
  output logic                       cmd_ready,
  output logic                       cmd_done,
  output logic                       cmd_nack,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid
);
  import eeprom_pkg::*;

  localparam int QW = $clog2(QC + 1);
  localparam int TW = $clog2(TC + 1);
  if (QC < 4 || TC < 1) begin : g_chk
    $error("QC must be at least 4 and TC at least 1");
  end

  localparam step_t SEQ_WR [8] = '{SP_START, SP_CTRL_W, SP_WORD, SP_DATA,
    SP_STOP, SP_STOP, SP_STOP, SP_STOP};
  localparam step_t SEQ_PL [8] = '{SP_START, SP_CTRL_W, SP_STOP, SP_STOP,
    SP_STOP, SP_STOP, SP_STOP, SP_STOP};
  localparam step_t SEQ_CR [8] = '{SP_START, SP_CTRL_R, SP_READ, SP_STOP,
    SP_STOP, SP_STOP, SP_STOP, SP_STOP};
  localparam step_t SEQ_RR [8] = '{SP_START, SP_CTRL_W, SP_WORD, SP_START,
    SP_CTRL_R, SP_READ, SP_STOP, SP_STOP};

  function automatic step_t step_of(input cmd_kind_t k, input logic [2:0] s);
    unique case (k)
      K_WRITE:     step_of = SEQ_WR[s];
      K_POLL:      step_of = SEQ_PL[s];
      K_CUR_READ:  step_of = SEQ_CR[s];
      K_RAND_READ: step_of = SEQ_RR[s];
      default:     step_of = SP_STOP;
    endcase
  endfunction : step_of

  logic          s1;
  logic          s2;
  logic [QW-1:0] tcnt;
  logic [TW-1:0] dcnt;
  bus_op_t       op;
  cmd_kind_t     kind;
  logic [1:0]    q;
  logic [3:0]    bitn;
  logic [7:0]    sh;
  logic [7:0]    addr;
  logic [7:0]    wdata;
  logic [7:0]    left;
  logic [2:0]    step;
  logic          stop_now;
  logic          rd;
  logic          drive;
  logic          sda_o_q;
  logic          scl_q;
  logic          toc_q;

  wire   tick = tcnt == '0;
  wire   step_t cur = stop_now ? SP_STOP : step_of(kind, step);
  assign bus.scl                 = scl_q;
  assign bus.transmit_only_clock = toc_q;
  assign bus.host_sda_o          = sda_o_q;
  assign bus.host_sda_oe         = drive;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      dcnt  <= '0;
      toc_q <= 1'b1;
    end else begin
      s1 <= bus.sda;
      s2 <= s1;
      // Free-running clock pin, or a level that gates writes
      dcnt <= (dcnt == '0) ? TW'(TC - 1) : dcnt - 1'b1;
      if (!toc_run) begin
        toc_q <= write_enable;
      end else if (dcnt == '0) begin
        toc_q <= ~toc_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    sda_o_q <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op <= OP_IDLE; kind <= K_POLL; q <= 2'h0; bitn <= 4'h0;
      sh <= 8'h00; addr <= 8'h00; wdata <= 8'h00; left <= 8'h00;
      step <= 3'h0; stop_now <= 1'b0; rd <= 1'b0; drive <= 1'b0;
      scl_q <= 1'b1;
      tcnt <= '0; cmd_ready <= 1'b1; cmd_done <= 1'b0;
      cmd_nack <= 1'b0; rd_data <= 8'h00; rd_valid <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      rd_valid <= 1'b0;
      tcnt     <= tick ? QW'(QC - 1) : tcnt - 1'b1;
      if (cmd_ready) begin
        if (cmd_valid) begin
          cmd_ready <= 1'b0;
          kind      <= cmd_kind;
          addr      <= cmd_addr;
          wdata     <= cmd_wdata;
          left      <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
          step      <= 3'h0;
          stop_now  <= 1'b0;
          cmd_nack  <= 1'b0;
        end
      end else if (op == OP_IDLE) begin
        q    <= 2'h0;
        bitn <= 4'h0;
        rd   <= cur == SP_READ;
        unique case (cur)
          SP_START:  op <= OP_START;
          SP_STOP:   op <= OP_STOP;
          SP_CTRL_W: begin sh <= {DEV_ADDR, 1'b0}; op <= OP_BIT; end
          SP_CTRL_R: begin sh <= {DEV_ADDR, 1'b1}; op <= OP_BIT; end
          SP_WORD:   begin sh <= addr; op <= OP_BIT; end
          SP_DATA:   begin sh <= wdata; op <= OP_BIT; end
          SP_READ:   op <= OP_BIT;
        endcase
      end else if (tick) begin
        q <= q + 2'h1;
        unique case (op)
          OP_START: begin
            // SDA moves only with SCL low, except here and in the STOP
            unique case (q)
              2'h0: drive <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: drive <= 1'b1;
              2'h3: begin scl_q <= 1'b0; op <= OP_IDLE; step <= step + 3'h1; end
            endcase
          end
          OP_STOP: begin
            unique case (q)
              2'h0: drive <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: drive <= 1'b0;
              2'h3: begin op <= OP_IDLE; cmd_ready <= 1'b1; cmd_done <= 1'b1; end
            endcase
          end
          default: begin
            unique case (q)
              2'h0: begin
                if (bitn != `BYTE_BITS) begin
                  drive <= !rd && !sh[7];
                end else begin
                  drive <= rd && left != 8'h01;
                end
              end
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bitn != `BYTE_BITS) begin
                  sh <= {sh[6:0], rd ? s2 : 1'b0};
                end else if (!rd && s2) begin
                  stop_now <= 1'b1;
                  cmd_nack <= 1'b1;
                end
              end
              2'h3: begin
                scl_q <= 1'b0;
                bitn  <= bitn + 4'h1;
                if (bitn == `BYTE_BITS) begin
                  op    <= OP_IDLE;
                  drive <= 1'b0;
                  if (rd) begin
                    rd_data  <= sh;
                    rd_valid <= 1'b1;
                    left     <= left - 8'h01;
                  end
                  if (!rd || left == 8'h01) begin
                    step <= step + 3'h1;
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule : eeprom_host
`default_nettype wire

/* File: test/eeprom_link_monitor.sv */
// Assertions on the link between the EEPROM host and device.
// Assumes link signals and device flags are sampled on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_monitor #(
  parameter int WR_CYC = 2000
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic transmit_only_clock,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic write_busy,
  input wire logic bidir_mode
);
  logic [15:0] busy_len;
  logic [3:0]  scl_hi;
  logic        toc_q;
  logic [3:0]  since_toc;
  wire         toc_rise;

  assign toc_rise = transmit_only_clock && !toc_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // scl_hi and since_toc saturate so long idle spans never wrap; busy_len does not
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_len  <= 16'h0;
      scl_hi    <= 4'h0;
      toc_q     <= 1'b1;
      since_toc <= 4'hf;
    end else begin
      busy_len  <= write_busy ? busy_len + 16'h1 : 16'h0;
      scl_hi    <= !scl ? 4'h0 : (scl_hi == 4'hf) ? scl_hi : scl_hi + 4'h1;
      toc_q     <= transmit_only_clock;
      since_toc <= toc_rise ? 4'h0 :
                   (since_toc == 4'hf) ? since_toc : since_toc + 4'h1;
    end
  end

  sda_low_only_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drove the data line high");
  mode_sticky_a: assert property (bidir_mode |=> bidir_mode)
    else $error("bidirectional mode was left");
  mode_entry_a: assert property ($rose(bidir_mode) |-> !$past(scl, 2))
    else $error("mode switched without a clock fall");
  mode_hold_a: assert property (!bidir_mode && scl_hi == 4'hf |=> !bidir_mode)
    else $error("mode switched with the clock idle high");
  busy_silent_a: assert property (write_busy |-> !dev_sda_oe)
    else $error("device drove the line during a write cycle");
  busy_after_stop_a: assert property (
    $rose(write_busy) |-> scl && sda && !$past(sda, 6))
    else $error("write cycle began without a stop");
  busy_length_a: assert property (
    $fell(write_busy) |-> busy_len >= WR_CYC - 1 && busy_len <= WR_CYC + 1)
    else $error("write cycle length wrong");
  busy_protect_a: assert property ($rose(write_busy) |-> transmit_only_clock)
    else $error("write cycle began with the clock pin low");
  stream_edge_a: assert property (
    !bidir_mode && scl_hi == 4'hf && $changed(dev_sda_oe) |-> since_toc <= 4'h6)
    else $error("stream bit moved away from a clock pin rise");
  drive_scl_low_a: assert property (
    bidir_mode && $changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device moved the data line with the clock high");
endmodule : eeprom_link_monitor
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench: host and device joined over the two-wire link.
// Assumes the package, interface and both design ends compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eeprom_pkg::*;
  localparam int WR_CYC = 600;
  localparam int LIMIT  = 60000;
  logic       sys_clk;
  logic       sys_rst;
  logic       supply_ok;
  logic       cmd_valid;
  cmd_kind_t  cmd_kind;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic [7:0] cmd_len;
  logic       toc_run;
  logic       write_enable;
  logic       cmd_ready;
  logic       cmd_done;
  logic       cmd_nack;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       write_busy;
  logic       bidir_mode;
  logic       alt_nack;
  logic       alt_bidir;
  logic [7:0] stream [2];
  logic [7:0] got[$];
  int         fails;
  int         n_tests;
  int         cycles;

  eeprom_if eeprom_if_inst ();
  eeprom_if alt_eeprom_if_inst ();
  eeprom_device #(.WR_CYC(WR_CYC)) eeprom_device_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(eeprom_if_inst.device),
    .supply_ok(supply_ok), .write_busy(write_busy), .bidir_mode(bidir_mode));
  eeprom_host #(.QC(8), .TC(16)) eeprom_host_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(eeprom_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .toc_run(toc_run),
    .write_enable(write_enable), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .cmd_nack(cmd_nack), .rd_data(rd_data), .rd_valid(rd_valid));
  // Second pair: host aims at an address the device does not own
  eeprom_device #(.WR_CYC(WR_CYC)) alt_eeprom_device_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(alt_eeprom_if_inst.device),
    .supply_ok(supply_ok), .write_busy(), .bidir_mode(alt_bidir));
  eeprom_host #(.DEV_ADDR(7'h3b), .QC(8), .TC(16)) alt_eeprom_host_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(alt_eeprom_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .toc_run(toc_run),
    .write_enable(write_enable), .cmd_ready(), .cmd_done(),
    .cmd_nack(alt_nack), .rd_data(), .rd_valid());
  eeprom_link_monitor #(.WR_CYC(WR_CYC)) eeprom_link_monitor_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl(eeprom_if_inst.scl),
    .transmit_only_clock(eeprom_if_inst.transmit_only_clock),
    .dev_sda_o(eeprom_if_inst.dev_sda_o),
    .dev_sda_oe(eeprom_if_inst.dev_sda_oe), .sda(eeprom_if_inst.sda),
    .write_busy(write_busy), .bidir_mode(bidir_mode));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    n_tests++;
    if (act !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
    end
  endtask : check

  // Called at a falling edge; returns at the falling edge showing done
  task automatic run_cmd(input cmd_kind_t kind, input logic [7:0] addr,
                         input logic [7:0] len);
    int n;
    got.delete();
    cmd_kind  = kind;
    cmd_addr  = addr;
    cmd_len   = len;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 5000) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      @(negedge sys_clk);
      n++;
    end
    if (cmd_done !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: command never completed", $time);
    end
  endtask : run_cmd

  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data,
                            input logic exp_busy);
    int tries;
    cmd_wdata = data;
    run_cmd(K_WRITE, addr, 8'h01);
    repeat (8) @(negedge sys_clk);
    check({7'h0, write_busy}, {7'h0, exp_busy});
    if (exp_busy) begin
      run_cmd(K_POLL, 8'h00, 8'h01);
      check({7'h0, cmd_nack}, 8'h01);
      tries = 0;
      while (cmd_nack === 1'b1 && tries < 8) begin
        run_cmd(K_POLL, 8'h00, 8'h01);
        tries++;
      end
      check({7'h0, cmd_nack}, 8'h00);
    end
  endtask : write_byte

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      $display("unexpected at %0t: run took too long", $time);
      stop_test();
    end
  end

  initial begin
    sys_rst      = 1'b1;
    supply_ok    = 1'b1;
    cmd_valid    = 1'b0;
    cmd_kind     = K_POLL;
    cmd_addr     = 8'h00;
    cmd_wdata    = 8'h00;
    cmd_len      = 8'h01;
    toc_run      = 1'b1;
    write_enable = 1'b1;
    fails        = 0;
    n_tests      = 0;
    cycles       = 0;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (400) @(negedge sys_clk);
    check({7'h0, bidir_mode}, 8'h00);
    toc_run = 1'b0;
    // First command only wakes the device; it is lost by design
    run_cmd(K_POLL, 8'h00, 8'h01);
    check({7'h0, bidir_mode}, 8'h01);
    check({7'h0, alt_bidir}, 8'h01);
    run_cmd(K_POLL, 8'h00, 8'h01);
    check({7'h0, cmd_nack}, 8'h00);
    check({7'h0, alt_nack}, 8'h01);
    write_byte(8'h7f, 8'hc3, 1'b1);
    write_byte(8'h00, 8'h96, 1'b1);
    write_byte(8'h01, 8'h69, 1'b1);
    run_cmd(K_RAND_READ, 8'h7f, 8'h03);
    check(got[0], 8'hc3);
    check(got[1], 8'h96);
    check(got[2], 8'h69);
    check({7'h0, write_busy}, 8'h00);
    run_cmd(K_RAND_READ, 8'h00, 8'h01);
    check(got[0], 8'h96);
    run_cmd(K_CUR_READ, 8'h00, 8'h01);
    check(got[0], 8'h69);
    check(8'(got.size()), 8'h01);
    write_enable = 1'b0;
    write_byte(8'h00, 8'h11, 1'b0);
    write_enable = 1'b1;
    supply_ok = 1'b0;
    write_byte(8'h01, 8'h22, 1'b0);
    supply_ok = 1'b1;
    repeat (WR_CYC) @(negedge sys_clk);
    run_cmd(K_RAND_READ, 8'h00, 8'h02);
    check(got[0], 8'h96);
    check(got[1], 8'h69);
    // Power cycle: array keeps its data and streams from location zero
    sys_rst = 1'b1;
    toc_run = 1'b1;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge eeprom_if_inst.transmit_only_clock);
      repeat (8) @(negedge sys_clk);
      stream[i / 8] = {stream[i / 8][6:0], eeprom_if_inst.sda};
    end
    check(stream[0], 8'h96);
    check(stream[1], 8'h69);
    check({7'h0, bidir_mode}, 8'h00);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
